// ### logic/btds_params.svh
`ifndef BTDS_PARAMS_SVH
`define BTDS_PARAMS_SVH

// instruction word layout
`define BTDS_WORD_W 14
`define BTDS_BTC_OP_MSB 13
`define BTDS_BTC_OP_LSB 10
`define BTDS_BTC_OP 4'h6
`define BTDS_DCZ_OP_MSB 13
`define BTDS_DCZ_OP_LSB 8
`define BTDS_DCZ_OP 6'h0B
`define BTDS_BIT_MSB 9
`define BTDS_BIT_LSB 7
`define BTDS_DEST_BIT 7
`define BTDS_REG_MSB 6
`define BTDS_REG_LSB 0

// destination select values
`define BTDS_DEST_ACC 1'h0
`define BTDS_DEST_FILE 1'h1

// instruction cycle phases, one oscillator clock each
`define BTDS_PHASES 4
`define BTDS_PHASE_W 2
`define BTDS_PH_FETCH 2'h0
`define BTDS_PH_READ 2'h1
`define BTDS_PH_EXEC 2'h2
`define BTDS_PH_WRITE 2'h3

// reset values
`define BTDS_RST_PHASE 2'h0
`define BTDS_RST_BIT 3'h0

`endif

// ### logic/btds_pkg.sv
package btds_pkg;

    typedef enum logic [1:0] {
        BTDS_KIND_NONE,
        BTDS_KIND_BIT_TEST,
        BTDS_KIND_COUNTDOWN
    } btds_kind_e;

    typedef enum logic {
        BTDS_MODE_EXEC,
        BTDS_MODE_FLUSH
    } btds_mode_e;

endpackage

// ### logic/btds_phase.sv
`timescale 1ns/10ps
`include "btds_params.svh"

module btds_phase #(
    parameter int PHASES = `BTDS_PHASES,
    parameter int PHASE_W = `BTDS_PHASE_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // phase of the instruction cycle
    output logic [PHASE_W-1:0] phase_r
);

    logic [PHASE_W-1:0] phase_nxt;

    always_comb begin
        if (phase_r == PHASE_W'(PHASES - 1)) begin
            phase_nxt = `BTDS_RST_PHASE;
        end else begin
            phase_nxt = phase_r + PHASE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_r <= `BTDS_RST_PHASE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

endmodule

// ### logic/btds_core.sv
`timescale 1ns/10ps
`include "btds_params.svh"

module btds_core #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fetched instruction, sampled in the fetch phase
    input wire logic [`BTDS_WORD_W-1:0] instr_word,
    // file register read, combinational from file_addr_r
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [ADDR_W-1:0] file_addr_r,
    output logic file_rd_r,
    // file register write
    output logic [DATA_W-1:0] file_wdata_r,
    output logic file_we_r,
    // accumulator write
    output logic [DATA_W-1:0] acc_wdata_r,
    output logic acc_we_r,
    // sequencing towards the instruction pointer, and the status flag write enable
    output logic [`BTDS_PHASE_W-1:0] phase_r,
    output logic skip_r,
    output logic nop_cycle_r,
    output logic status_we_r
);

    btds_pkg::btds_kind_e kind_r, kind_nxt;
    btds_pkg::btds_mode_e mode_r, mode_nxt;
    logic [ADDR_W-1:0] file_addr_nxt;
    logic [2:0] bit_sel_r, bit_sel_nxt;
    logic dest_r, dest_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic [DATA_W-1:0] file_wdata_nxt, acc_wdata_nxt;
    logic [DATA_W-1:0] result;
    logic file_rd_nxt, file_we_nxt, acc_we_nxt;
    logic skip_nxt, nop_cycle_nxt;

    function automatic btds_pkg::btds_kind_e decode_kind(
        input logic [`BTDS_WORD_W-1:0] w
    );
        btds_pkg::btds_kind_e k;
        k = btds_pkg::BTDS_KIND_NONE;
        if (w[`BTDS_BTC_OP_MSB:`BTDS_BTC_OP_LSB] == `BTDS_BTC_OP) begin
            k = btds_pkg::BTDS_KIND_BIT_TEST;
        end else if (w[`BTDS_DCZ_OP_MSB:`BTDS_DCZ_OP_LSB] == `BTDS_DCZ_OP)
        begin
            k = btds_pkg::BTDS_KIND_COUNTDOWN;
        end
        return k;
    endfunction

    // phase counter; the flush cycle runs on the same four phases
    btds_phase #(
        .PHASES(`BTDS_PHASES),
        .PHASE_W(`BTDS_PHASE_W)
    ) u_phase (
        .clk(clk),
        .rstn(rstn),
        .phase_r(phase_r)
    );

    always_comb begin
        kind_nxt = kind_r;
        mode_nxt = mode_r;
        file_addr_nxt = file_addr_r;
        bit_sel_nxt = bit_sel_r;
        dest_nxt = dest_r;
        data_nxt = data_r;
        file_wdata_nxt = file_wdata_r;
        acc_wdata_nxt = acc_wdata_r;
        file_rd_nxt = file_rd_r;
        file_we_nxt = 1'b0;
        acc_we_nxt = 1'b0;
        skip_nxt = 1'b0;
        nop_cycle_nxt = nop_cycle_r;
        result = data_r - DATA_W'(1);
        case (phase_r)
            `BTDS_PH_FETCH: begin
                if (mode_r == btds_pkg::BTDS_MODE_EXEC) begin
                    kind_nxt = decode_kind(instr_word);
                    file_addr_nxt =
                        instr_word[`BTDS_REG_MSB:`BTDS_REG_LSB];
                    bit_sel_nxt = instr_word[`BTDS_BIT_MSB:`BTDS_BIT_LSB];
                    dest_nxt = instr_word[`BTDS_DEST_BIT];
                    file_rd_nxt = (kind_nxt != btds_pkg::BTDS_KIND_NONE);
                end else begin
                    // prefetched word is dropped, this cycle is a nop
                    kind_nxt = btds_pkg::BTDS_KIND_NONE;
                    file_rd_nxt = 1'b0;
                end
            end
            `BTDS_PH_READ: begin
                data_nxt = file_rdata;
                file_rd_nxt = 1'b0;
            end
            `BTDS_PH_EXEC: begin
                case (kind_r)
                    btds_pkg::BTDS_KIND_BIT_TEST: begin
                        skip_nxt = ~data_r[bit_sel_r];
                    end
                    btds_pkg::BTDS_KIND_COUNTDOWN: begin
                        if (dest_r == `BTDS_DEST_FILE) begin
                            file_we_nxt = 1'b1;
                            file_wdata_nxt = result;
                        end else begin
                            acc_we_nxt = 1'b1;
                            acc_wdata_nxt = result;
                        end
                        skip_nxt = (result == '0);
                    end
                    default: begin
                        skip_nxt = 1'b0;
                    end
                endcase
            end
            `BTDS_PH_WRITE: begin
                // a skip turns the next whole cycle into a nop
                if (skip_r) begin
                    mode_nxt = btds_pkg::BTDS_MODE_FLUSH;
                    nop_cycle_nxt = 1'b1;
                end else begin
                    mode_nxt = btds_pkg::BTDS_MODE_EXEC;
                    nop_cycle_nxt = 1'b0;
                end
            end
            default: begin
                mode_nxt = mode_r;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            kind_r <= btds_pkg::BTDS_KIND_NONE;
            mode_r <= btds_pkg::BTDS_MODE_EXEC;
            file_addr_r <= '0;
            bit_sel_r <= `BTDS_RST_BIT;
            dest_r <= `BTDS_DEST_ACC;
            data_r <= '0;
            file_wdata_r <= '0;
            acc_wdata_r <= '0;
            file_rd_r <= 1'b0;
            file_we_r <= 1'b0;
            acc_we_r <= 1'b0;
            skip_r <= 1'b0;
            nop_cycle_r <= 1'b0;
            status_we_r <= 1'b0;
        end else begin
            kind_r <= kind_nxt;
            mode_r <= mode_nxt;
            file_addr_r <= file_addr_nxt;
            bit_sel_r <= bit_sel_nxt;
            dest_r <= dest_nxt;
            data_r <= data_nxt;
            file_wdata_r <= file_wdata_nxt;
            acc_wdata_r <= acc_wdata_nxt;
            file_rd_r <= file_rd_nxt;
            file_we_r <= file_we_nxt;
            acc_we_r <= acc_we_nxt;
            skip_r <= skip_nxt;
            nop_cycle_r <= nop_cycle_nxt;
            // flags are never touched by these two instructions
            status_we_r <= 1'b0;
        end
    end

    AST_BIT_TEST_DECODE:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_READ && $past(mode_r) ==
        btds_pkg::BTDS_MODE_EXEC && $past(instr_word[13:10]) == 4'h6)
        |-> kind_r == btds_pkg::BTDS_KIND_BIT_TEST && file_rd_r &&
        file_addr_r == $past(instr_word[6:0]) &&
        bit_sel_r == $past(instr_word[9:7]))
    else $error("bit test word not decoded");

    AST_BIT_TEST_SKIP:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_READ &&
        kind_r == btds_pkg::BTDS_KIND_BIT_TEST)
        |-> ##2 skip_r == ~$past(file_rdata[bit_sel_r], 2) &&
        !file_we_r && !acc_we_r)
    else $error("bit test skip decision wrong");

    AST_SKIP_FLUSH:
    assert property (@(posedge clk) disable iff (!rstn)
        (skip_r && phase_r == `BTDS_PH_WRITE)
        |=> nop_cycle_r ##1 (kind_r == btds_pkg::BTDS_KIND_NONE &&
        !file_rd_r) ##2 (!skip_r && !file_we_r && !acc_we_r) ##1
        !nop_cycle_r)
    else $error("skip did not insert a single nop cycle");

    AST_COUNTDOWN_VALUE:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_READ &&
        kind_r == btds_pkg::BTDS_KIND_COUNTDOWN)
        |-> ##2 (file_we_r ? file_wdata_r : acc_wdata_r) ==
        $past(file_rdata, 2) - 8'h01)
    else $error("countdown result is not value minus one");

    AST_COUNTDOWN_DEST:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_EXEC &&
        kind_r == btds_pkg::BTDS_KIND_COUNTDOWN)
        |=> (file_we_r == dest_r) && (acc_we_r == !dest_r))
    else $error("countdown written to wrong destination");

    AST_COUNTDOWN_SKIP:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_EXEC &&
        kind_r == btds_pkg::BTDS_KIND_COUNTDOWN)
        |=> skip_r == ($past(data_r) == 8'h01))
    else $error("countdown skip decision wrong");

    AST_NO_SKIP_ONE_CYCLE:
    assert property (@(posedge clk) disable iff (!rstn)
        (phase_r == `BTDS_PH_WRITE && !skip_r)
        |=> mode_r == btds_pkg::BTDS_MODE_EXEC && !nop_cycle_r)
    else $error("nop cycle without a skip");

    // sampled rstn keeps the release edge, still a reset edge, out
    AST_FOUR_PHASES:
    assert property (@(posedge clk) disable iff (!rstn)
        (rstn && phase_r == `BTDS_PH_FETCH) |=> phase_r == `BTDS_PH_READ ##1
        phase_r == `BTDS_PH_EXEC ##1 phase_r == `BTDS_PH_WRITE ##1
        phase_r == `BTDS_PH_FETCH)
    else $error("instruction cycle is not four clocks");

    AST_NO_FLAGS:
    assert property (@(posedge clk) disable iff (!rstn)
        (skip_r || file_we_r || acc_we_r) |-> !status_we_r)
    else $error("status flags written");

endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
`include "btds_params.svh"

module tb_top;
    logic clk;
    logic rstn;
    logic [`BTDS_WORD_W-1:0] instr_word;
    logic [7:0] file_rdata;
    logic [6:0] file_addr_r;
    logic file_rd_r;
    logic [7:0] file_wdata_r;
    logic file_we_r;
    logic [7:0] acc_wdata_r;
    logic acc_we_r;
    logic [1:0] phase_r;
    logic skip_r;
    logic nop_cycle_r;
    logic status_we_r;
    int failures;
    int n_checks;

    btds_core dut (.clk(clk), .rstn(rstn), .instr_word(instr_word),
        .file_rdata(file_rdata), .file_addr_r(file_addr_r),
        .file_rd_r(file_rd_r), .file_wdata_r(file_wdata_r),
        .file_we_r(file_we_r), .acc_wdata_r(acc_wdata_r),
        .acc_we_r(acc_we_r), .phase_r(phase_r), .skip_r(skip_r),
        .nop_cycle_r(nop_cycle_r), .status_we_r(status_we_r));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one instruction from take to the start of the next real cycle
    task automatic run(input logic [13:0] w, input logic [7:0] rd,
        input logic e_rd, input logic e_fwe, input logic e_awe,
        input logic e_skip, input logic [7:0] e_wd);
        int n;
        n = 0;
        while (phase_r !== 2'h3 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        instr_word <= w;
        file_rdata <= rd;
        @(posedge clk);
        #1;
        check({6'h00, phase_r}, 8'h01);
        check({7'h00, file_rd_r}, {7'h00, e_rd});
        if (e_rd) begin
            check({1'b0, file_addr_r}, {1'b0, w[6:0]});
        end
        @(posedge clk);
        #1;
        check({phase_r, file_rd_r, file_we_r, acc_we_r, 3'h0},
            8'h80);
        @(posedge clk);
        #1;
        check({7'h00, skip_r}, {7'h00, e_skip});
        check({5'h00, file_we_r, acc_we_r, status_we_r},
            {5'h00, e_fwe, e_awe, 1'b0});
        if (e_fwe) begin
            check(file_wdata_r, e_wd);
        end
        if (e_awe) begin
            check(acc_wdata_r, e_wd);
        end
        @(posedge clk);
        // a recognised word in the nop cycle must be discarded
        instr_word <= e_skip ? 14'h0BFF : 14'h0000;
        file_rdata <= 8'h05;
        #1;
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                @(posedge clk);
                #1;
            end
            check({phase_r, nop_cycle_r, file_rd_r, file_we_r, acc_we_r,
                skip_r, 1'b0},
                {2'(k), e_skip, 5'h00});
            if (!e_skip) begin
                break;
            end
        end
    endtask

    task automatic t_reset();
        rstn <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            if (i == 3) begin
                rstn <= 1'b1;
            end
            #1;
            // first look falls where a cut write would have landed
            check({phase_r, file_rd_r, file_we_r, acc_we_r, skip_r,
                nop_cycle_r, status_we_r}, 8'h00);
        end
    endtask

    task automatic t_bit_test();
        for (int b = 0; b < 8; b++) begin
            run({4'h6, 3'(b), 7'(b * 9)}, ~(8'h01 << b), 1'b1, 1'b0, 1'b0,
                1'b1, 8'h00);
            run({4'h6, 3'(b), 7'(127 - b)}, 8'h01 << b, 1'b1, 1'b0, 1'b0,
                1'b0, 8'h00);
        end
    endtask

    task automatic t_countdown();
        run({6'h0B, 1'b1, 7'h11}, 8'h01, 1'b1, 1'b1, 1'b0, 1'b1,
            8'h00);
        run({6'h0B, 1'b1, 7'h7F}, 8'h05, 1'b1, 1'b1, 1'b0, 1'b0,
            8'h04);
        run({6'h0B, 1'b0, 7'h00}, 8'h01, 1'b1, 1'b0, 1'b1, 1'b1,
            8'h00);
        run({6'h0B, 1'b0, 7'h22}, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0,
            8'hFF);
        run({6'h0B, 1'b1, 7'h40}, 8'h80, 1'b1, 1'b1, 1'b0, 1'b0,
            8'h7F);
    endtask

    // reset in mid-instruction must drop the pending write and skip
    task automatic t_midreset();
        while (phase_r !== 2'h3) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        instr_word <= {6'h0B, 1'b1, 7'h01};
        file_rdata <= 8'h01;
        repeat (2) @(posedge clk);
        instr_word <= 14'h0000;
        t_reset();
        // release cycle is phase 0, its take moves the phase on
        @(posedge clk);
        #1;
        check({phase_r, file_rd_r, file_we_r, acc_we_r, skip_r,
            nop_cycle_r, status_we_r}, 8'h40);
    endtask

    // neighbouring opcodes belong to other decoders
    task automatic t_other();
        run(14'h1C05, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        run(14'h0A85, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        run(14'h1005, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    initial begin
        #10000;
        failures++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        instr_word = 14'h0000;
        file_rdata = 8'h00;
        failures = 0;
        n_checks = 0;
        t_reset();
        t_bit_test();
        t_countdown();
        t_midreset();
        t_other();
        conclude();
    end
endmodule
